// >>> logic/edpo_map.svh
`ifndef EDPO_MAP_SVH
`define EDPO_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define EDPO_A_CTRL    8'h00
`define EDPO_A_PPR     8'h04
`define EDPO_A_LRES    8'h08
`define EDPO_A_NCNT    8'h0C
`define EDPO_A_STAT    8'h10

// ************************************************************
// Field positions
// ************************************************************
`define EDPO_B_ORG_BIDIR  0
`define EDPO_B_MOT_REV    1
`define EDPO_B_LINEAR     2
`define EDPO_B_RESTART    8
`define EDPO_B_ARMED      0
`define EDPO_B_OVS        1
`define EDPO_B_QA         2
`define EDPO_B_QB         3
`define EDPO_B_QC         4

// ************************************************************
// Reset values
// ************************************************************
`define EDPO_CTRL_RST  3'h0
`define EDPO_PPR_RST   31'h00000800
`define EDPO_LRES_RST  13'h0014
`define EDPO_NCNT_RST  32'h00100000

// ************************************************************
// Timing
// ************************************************************
`define EDPO_CLK_HZ    32'h0EE6B280
`define EDPO_MAX_PPS   32'h00186A00
`define EDPO_EDGE_GAP  ((`EDPO_CLK_HZ + 4 * `EDPO_MAX_PPS - 1) / (4 * `EDPO_MAX_PPS))

`endif

// >>> logic/edpo_pkg.sv
package edpo_pkg;

  // Quadrature phase states, named by levels of A and B
  typedef enum logic [3:0] {
    PH_00 = 4'b0001,
    PH_10 = 4'b0010,
    PH_11 = 4'b0100,
    PH_01 = 4'b1000
  } edpo_ph_t;

  // Origin pulse states
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_WAIT = 3'b010,
    C_HIGH = 3'b100
  } edpo_c_t;

endpackage : edpo_pkg

// >>> logic/edpo_quad_gen.sv
`include "edpo_map.svh"

module edpo_quad_gen #(
  parameter int PEND_W = 8
) (
  // Clock, reset, enable
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic restart,
  // Step requests
  input  wire logic step_req,
  input  wire logic step_fwd,
  // Quadrature outputs
  output logic      qa,
  output logic      qa_n,
  output logic      qb,
  output logic      qb_n,
  output logic      ovs
);

  localparam int GAP = `EDPO_EDGE_GAP;
  localparam logic signed [PEND_W-1:0] PMAX = {1'b0, {(PEND_W-1){1'b1}}};
  localparam logic signed [PEND_W-1:0] PMIN = -PMAX;

  if (PEND_W < 3 || GAP < 2 || GAP > 127) begin : g_chk
    $error("edpo_quad_gen: unsupported PEND_W or edge gap");
  end

  edpo_pkg::edpo_ph_t        ph_q, ph_d;
  logic signed [PEND_W-1:0]  pend_q, pend_d;
  logic [6:0]                gap_q, gap_d;
  logic                      ovs_d, mv, mv_fwd;
  logic                      qa_d, qb_d;

  // ************************************************************
  // Next state: pending steps, paced edges
  // ************************************************************
  always_comb begin
    pend_d = pend_q;
    ph_d   = ph_q;
    gap_d  = (gap_q != 7'h00) ? gap_q - 7'h01 : 7'h00;
    ovs_d  = 1'b0;
    mv     = 1'b0;
    mv_fwd = 1'b0;
    // Count requests, flag overflow of backlog
    if (step_req) begin
      if (step_fwd) begin
        if (pend_q == PMAX) ovs_d = 1'b1;
        else pend_d = pend_q + 1'b1;
      end else begin
        if (pend_q == PMIN) ovs_d = 1'b1;
        else pend_d = pend_q - 1'b1;
      end
    end
    // One edge per gap keeps the output under the rate bound
    if (gap_q == 7'h00 && pend_d != '0) begin
      mv     = 1'b1;
      mv_fwd = !pend_d[PEND_W-1];
      pend_d = mv_fwd ? pend_d - 1'b1 : pend_d + 1'b1;
      gap_d  = 7'(GAP - 1);
      // Forward order 00,10,11,01: A leads B by a quarter period
      case (ph_q)
        edpo_pkg::PH_00: ph_d = mv_fwd ? edpo_pkg::PH_10 : edpo_pkg::PH_01;
        edpo_pkg::PH_10: ph_d = mv_fwd ? edpo_pkg::PH_11 : edpo_pkg::PH_00;
        edpo_pkg::PH_11: ph_d = mv_fwd ? edpo_pkg::PH_01 : edpo_pkg::PH_10;
        edpo_pkg::PH_01: ph_d = mv_fwd ? edpo_pkg::PH_00 : edpo_pkg::PH_11;
        default:         ph_d = edpo_pkg::PH_00;
      endcase
    end
    if (restart) begin
      pend_d = '0;
      ph_d   = edpo_pkg::PH_00;
    end
    qa_d = (ph_d == edpo_pkg::PH_10) || (ph_d == edpo_pkg::PH_11);
    qb_d = (ph_d == edpo_pkg::PH_11) || (ph_d == edpo_pkg::PH_01);
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_q   <= edpo_pkg::PH_00;
      pend_q <= '0;
      gap_q  <= 7'h00;
      ovs    <= 1'b0;
      qa     <= 1'b0;
      qa_n   <= 1'b1;
      qb     <= 1'b0;
      qb_n   <= 1'b1;
    end else if (ce) begin
      ph_q   <= ph_d;
      pend_q <= pend_d;
      gap_q  <= gap_d;
      ovs    <= ovs_d;
      qa     <= qa_d;
      qa_n   <= !qa_d;
      qb     <= qb_d;
      qb_n   <= !qb_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [6:0] since_q;
  logic       last_fwd_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      since_q    <= 7'h7F;
      last_fwd_q <= 1'b0;
    end else if (ce) begin
      since_q    <= (mv && !restart) ? 7'h00 : (since_q == 7'h7F ? since_q : since_q + 7'h01);
      last_fwd_q <= mv ? mv_fwd : last_fwd_q;
    end
  end

  // A restart may drop both phases to zero at once, so that edge is exempt
  chk_ab_one_edge: assert property (@(posedge mclk) disable iff (rst)
    !$past(restart) |-> !($changed(qa) && $changed(qb)))
    else $error("A and B changed together");
  chk_pair_comp: assert property (@(posedge mclk) disable iff (rst)
    (qa_n == !qa) && (qb_n == !qb)) else $error("Complement pair broken");
  chk_fwd_lead: assert property (@(posedge mclk) disable iff (rst)
    ($rose(qa) && !restart) |-> (qb == !last_fwd_q)) else $error("Phase lead wrong");
  chk_edge_gap: assert property (@(posedge mclk) disable iff (rst)
    (ce && mv && !restart) |-> (since_q >= 7'(GAP - 1))) else $error("Edges too close");

endmodule : edpo_quad_gen

// >>> logic/edpo_top.sv
`include "edpo_map.svh"

// Contract
// - Emit complementary phase A and B trains a quarter period apart.
// - Rotary: configured pulses per revolution are output each revolution.
// - Linear: output follows configured edges per pitch, keeping quadrature.
// - Emit one complementary phase C origin pulse per revolution.
// - Phase C width equals one phase A pulse width.
// - Reversed motor direction keeps the same A, B, C phase form.
// - Origin select 0 emits C forward only, 1 both ways; after restart.
// - Bidirectional origin mode may give a C pulse narrower than A.
// - Forward-only and bidirectional C positions differ by an eighth pitch.
// - Forward-only linear: encoder count direction decides C, not motor select.
// - First forward crossing emits C; later crossings emit both ways.
// - Reverse crossings give no C until a forward C has been emitted.
// - Direction-dependent reference marks give C at two positions.
// - Output rate bounded near 1.6 Mpps; excess raises overspeed alarm.
module edpo_top #(
  parameter int PEND_W = 8
) (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Internal encoder position
  input  wire logic        enc_step,
  input  wire logic        enc_up,
  input  wire logic        enc_origin,
  // Pulse outputs
  output logic             quad_phase_a_out,
  output logic             quad_phase_a_out_n,
  output logic             quad_phase_b_out,
  output logic             quad_phase_b_out_n,
  output logic             origin_pulse_out,
  output logic             origin_pulse_out_n
);

  if (PEND_W < 3) begin : g_chk
    $error("edpo_top: PEND_W too small");
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [2:0]  ctrl_q, ctrl_d, act_q, act_d;
  logic [30:0] ppr_q, ppr_d, ppr_act_q, ppr_act_d;
  logic [12:0] lres_q, lres_d, lres_act_q, lres_act_d;
  logic [31:0] ncnt_q, ncnt_d, ncnt_act_q, ncnt_act_d;
  logic [31:0] rdata_d;
  logic        ovs_q, ovs_d, restart;
  logic        armed_q, armed_d;
  logic        ovs_pulse;

  // Decode writes, keep sticky alarm, build read data
  always_comb begin
    ctrl_d     = ctrl_q;
    ppr_d      = ppr_q;
    lres_d     = lres_q;
    ncnt_d     = ncnt_q;
    restart    = 1'b0;
    rdata_d    = 32'h00000000;
    ovs_d      = ovs_q;
    if (reg_wr) begin
      case (reg_addr)
        `EDPO_A_CTRL: begin
          ctrl_d  = reg_wdata[2:0];
          restart = reg_wdata[`EDPO_B_RESTART];
        end
        `EDPO_A_PPR:  ppr_d  = reg_wdata[30:0];
        `EDPO_A_LRES: lres_d = reg_wdata[12:0];
        `EDPO_A_NCNT: ncnt_d = reg_wdata;
        `EDPO_A_STAT: if (reg_wdata[`EDPO_B_OVS]) ovs_d = 1'b0;
        default: ;
      endcase
    end
    // Alarm set wins over a clear in the same cycle
    if (ovs_pulse) ovs_d = 1'b1;
    // Settings take effect only at restart
    act_d      = restart ? ctrl_d : act_q;
    ppr_act_d  = restart ? ppr_d  : ppr_act_q;
    lres_act_d = restart ? lres_d : lres_act_q;
    ncnt_act_d = restart ? ncnt_d : ncnt_act_q;
    if (reg_rd) begin
      case (reg_addr)
        `EDPO_A_CTRL: rdata_d = {29'h00000000, ctrl_q};
        `EDPO_A_PPR:  rdata_d = {1'b0, ppr_q};
        `EDPO_A_LRES: rdata_d = {19'h00000, lres_q};
        `EDPO_A_NCNT: rdata_d = ncnt_q;
        `EDPO_A_STAT: rdata_d = {27'h0000000, origin_pulse_out,
                                 quad_phase_b_out, quad_phase_a_out, ovs_q, armed_q};
        default:      rdata_d = 32'h00000000;
      endcase
    end
  end

  // Register bank
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q     <= `EDPO_CTRL_RST;
      act_q      <= `EDPO_CTRL_RST;
      ppr_q      <= `EDPO_PPR_RST;
      ppr_act_q  <= `EDPO_PPR_RST;
      lres_q     <= `EDPO_LRES_RST;
      lres_act_q <= `EDPO_LRES_RST;
      ncnt_q     <= `EDPO_NCNT_RST;
      ncnt_act_q <= `EDPO_NCNT_RST;
      ovs_q      <= 1'b0;
      reg_rdata  <= 32'h00000000;
    end else if (ce) begin
      ctrl_q     <= ctrl_d;
      act_q      <= act_d;
      ppr_q      <= ppr_d;
      ppr_act_q  <= ppr_act_d;
      lres_q     <= lres_d;
      lres_act_q <= lres_act_d;
      ncnt_q     <= ncnt_d;
      ncnt_act_q <= ncnt_act_d;
      ovs_q      <= ovs_d;
      reg_rdata  <= rdata_d;
    end
  end

  // ************************************************************
  // Divider
  // ************************************************************
  logic        bidir, mot_rev, lin, eff_fwd, cfwd;
  logic [32:0] inc, acc_q, acc_d, sum, ncnt33;
  logic        step_req, step_fwd;

  // Accumulate output edges per encoder count, one edge at most
  always_comb begin
    bidir    = act_q[`EDPO_B_ORG_BIDIR];
    mot_rev  = act_q[`EDPO_B_MOT_REV];
    lin      = act_q[`EDPO_B_LINEAR];
    eff_fwd  = enc_up ^ mot_rev;
    // Forward-only linear origin follows the raw count direction
    cfwd     = (lin && !bidir) ? enc_up : eff_fwd;
    ncnt33   = {1'b0, ncnt_act_q};
    inc      = lin ? {20'h00000, lres_act_q} : {ppr_act_q, 2'b00};
    sum      = acc_q + inc;
    acc_d    = acc_q;
    step_req = 1'b0;
    step_fwd = eff_fwd;
    if (enc_step) begin
      if (enc_up) begin
        if (sum >= ncnt33) begin
          acc_d    = sum - ncnt33;
          step_req = 1'b1;
        end else begin
          acc_d = sum;
        end
      end else if (acc_q >= inc) begin
        acc_d = acc_q - inc;
      end else begin
        acc_d    = acc_q + ncnt33 - inc;
        step_req = 1'b1;
      end
    end
    if (restart) acc_d = 33'h000000000;
  end

  always_ff @(posedge mclk) begin
    if (rst) acc_q <= 33'h000000000;
    else if (ce) acc_q <= acc_d;
  end

  edpo_quad_gen #(
    .PEND_W (PEND_W)
  ) u_quad (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .restart  (restart),
    .step_req (step_req),
    .step_fwd (step_fwd),
    .qa       (quad_phase_a_out),
    .qa_n     (quad_phase_a_out_n),
    .qb       (quad_phase_b_out),
    .qb_n     (quad_phase_b_out_n),
    .ovs      (ovs_pulse)
  );

  // ************************************************************
  // Origin detection and phase C
  // ************************************************************
  edpo_pkg::edpo_c_t c_st_q, c_st_d;
  logic [28:0] offs_q, offs_d;
  logic        run_q, run_d, det, det_fwd, emit;
  logic        a_prev_q, a_rise, a_fall, c_d;

  always_comb begin
    offs_d  = offs_q;
    run_d   = run_q;
    det     = 1'b0;
    det_fwd = cfwd;
    a_rise  = quad_phase_a_out && !a_prev_q;
    a_fall  = !quad_phase_a_out && a_prev_q;
    if (bidir) begin
      // Detect at the mark itself, each mark in either direction
      det = enc_origin;
    end else begin
      // Forward-only detects an eighth of a pitch past the mark
      det_fwd = 1'b1;
      if (enc_origin && cfwd) begin
        offs_d = ncnt_act_q[31:3];
        run_d  = (ncnt_act_q[31:3] != 29'h00000000);
        det    = (ncnt_act_q[31:3] == 29'h00000000);
      end else if (run_q && enc_step) begin
        if (!cfwd) begin
          run_d = 1'b0;
        end else if (offs_q <= 29'h00000001) begin
          run_d = 1'b0;
          det   = 1'b1;
        end else begin
          offs_d = offs_q - 29'h00000001;
        end
      end
    end
    // Reverse marks wait for a first forward pulse
    emit    = det && (det_fwd || armed_q);
    armed_d = armed_q || (emit && det_fwd);
    c_st_d  = c_st_q;
    case (c_st_q)
      edpo_pkg::C_IDLE: begin
        if (emit) begin
          // Bidirectional rises at once and may be cut short
          c_st_d = bidir ? edpo_pkg::C_HIGH : edpo_pkg::C_WAIT;
        end
      end
      edpo_pkg::C_WAIT: begin
        if (a_rise) c_st_d = edpo_pkg::C_HIGH;
      end
      edpo_pkg::C_HIGH: begin
        if (a_fall) c_st_d = edpo_pkg::C_IDLE;
      end
      default: c_st_d = edpo_pkg::C_IDLE;
    endcase
    if (restart) begin
      c_st_d  = edpo_pkg::C_IDLE;
      armed_d = 1'b0;
      run_d   = 1'b0;
    end
    c_d = (c_st_d == edpo_pkg::C_HIGH);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      c_st_q             <= edpo_pkg::C_IDLE;
      offs_q             <= 29'h00000000;
      run_q              <= 1'b0;
      armed_q            <= 1'b0;
      a_prev_q           <= 1'b0;
      origin_pulse_out   <= 1'b0;
      origin_pulse_out_n <= 1'b1;
    end else if (ce) begin
      c_st_q             <= c_st_d;
      offs_q             <= offs_d;
      run_q              <= run_d;
      armed_q            <= armed_d;
      a_prev_q           <= quad_phase_a_out;
      origin_pulse_out   <= c_d;
      origin_pulse_out_n <= !c_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_unarmed_rev;
    ce && !restart && det && !det_fwd && !armed_q && c_st_q == edpo_pkg::C_IDLE;
  endsequence

  sequence s_fwd_origin;
    ce && !restart && det && det_fwd;
  endsequence

  chk_rev_needs_arm: assert property (@(posedge mclk) disable iff (rst)
    s_unarmed_rev |=> (c_st_q == edpo_pkg::C_IDLE) && !armed_q)
    else $error("Reverse origin emitted before arming");
  chk_arm_on_fwd: assert property (@(posedge mclk) disable iff (rst)
    s_fwd_origin |=> armed_q) else $error("Forward origin did not arm");
  // C trails A by one cycle at both ends, so the delayed copy of A covers its tail
  chk_c_in_a: assert property (@(posedge mclk) disable iff (rst)
    (origin_pulse_out && !bidir) |-> (quad_phase_a_out || a_prev_q))
    else $error("C outside A");
  chk_c_ends_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && a_fall && c_st_q == edpo_pkg::C_HIGH) |=> !origin_pulse_out)
    else $error("C outlasted A");
  chk_ovs_sticky: assert property (@(posedge mclk) disable iff (rst)
    (ce && ovs_pulse) |=> ovs_q) else $error("Overspeed not latched");
  chk_c_comp: assert property (@(posedge mclk) disable iff (rst)
    origin_pulse_out_n == !origin_pulse_out) else $error("C pair broken");

endmodule : edpo_top

// >>> testbench/edpo_host_model.sv
`include "edpo_map.svh"

module edpo_host_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Pulse pairs from the drive
  input  wire logic qa,
  input  wire logic qa_n,
  input  wire logic qb,
  input  wire logic qb_n,
  input  wire logic qc,
  input  wire logic qc_n,
  // What the host has counted
  output int        edges,
  output int        c_pulses,
  output int        c_width,
  output int        a_width,
  output int        faults
);
  timeunit 1ns;
  timeprecision 1ps;
  int         gap;
  int         a_run;
  int         c_run;
  int         a_last;
  logic [1:0] idx_q;
  logic [1:0] idx;

  // Position within one cycle, forward order 00,10,11,01
  assign idx = {qb, qa ^ qb};

  // Count quadrature edges, time the pulses, log protocol faults
  // Homing on phase C is left to the user, after two turns or at low speed
  always @(posedge mclk) begin
    if (rst) begin
      edges    <= 0;
      c_pulses <= 0;
      faults   <= 0;
      gap      <= 1000;
      idx_q    <= 2'h0;
      a_run    <= 0;
      c_run    <= 0;
    end else begin
      gap   <= gap + 1;
      idx_q <= idx;
      a_run <= qa ? a_run + 1 : 0;
      c_run <= qc ? c_run + 1 : 0;
      if (qa_n === qa || qb_n === qb || qc_n === qc) begin
        faults <= faults + 1;
      end
      if (idx != idx_q) begin
        gap <= 1;
        if (gap < `EDPO_EDGE_GAP) begin
          faults <= faults + 1;
        end
        if (idx - idx_q == 2'h1) begin
          edges <= edges + 1;
        end else if (idx - idx_q == 2'h3) begin
          edges <= edges - 1;
        end else begin
          faults <= faults + 1;
        end
      end
      // Width of the latest A pulse, reported with the C pulse that rode on it
      if (!qa && a_run > 0) begin
        a_last <= a_run;
      end
      if (!qc && c_run > 0) begin
        c_pulses <= c_pulses + 1;
        c_width  <= c_run;
        a_width  <= a_last;
      end
    end
  end
endmodule : edpo_host_model

// >>> testbench/tb_encoder_divided_pulse_output.sv
`include "edpo_map.svh"

module tb_encoder_divided_pulse_output;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus
  logic        mclk, rst, ce, reg_wr, reg_rd, enc_step, enc_up, enc_origin;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  // Observation
  logic [31:0] reg_rdata;
  logic        qa, qa_n, qb, qb_n, qc, qc_n;
  int          edges, c_pulses, c_width, a_width, faults;
  // Bookkeeping and active settings
  int          mismatches, checks_done, cycles, seed;
  int          cur_ppr, cur_lres, cur_ncnt;
  logic        cur_lin, cur_rev;

  edpo_top dut_u (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_step(enc_step),
    .enc_up(enc_up), .enc_origin(enc_origin), .quad_phase_a_out(qa),
    .quad_phase_a_out_n(qa_n), .quad_phase_b_out(qb), .quad_phase_b_out_n(qb_n),
    .origin_pulse_out(qc), .origin_pulse_out_n(qc_n)
  );

  edpo_host_model host_u (
    .mclk(mclk), .rst(rst), .qa(qa), .qa_n(qa_n), .qb(qb), .qb_n(qb_n), .qc(qc),
    .qc_n(qc_n), .edges(edges), .c_pulses(c_pulses), .c_width(c_width),
    .a_width(a_width), .faults(faults)
  );

  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check(what, exp, reg_rdata & m);
  endtask : rd_chk

  // Load settings, then restart so they become active
  task automatic cfg(input logic [2:0] ctrl, input int ppr, input int lres, input int ncnt);
    cur_lin  = ctrl[2];
    cur_rev  = ctrl[1];
    cur_ppr  = ppr;
    cur_lres = lres;
    cur_ncnt = ncnt;
    wr(`EDPO_A_PPR, ppr);
    wr(`EDPO_A_LRES, lres);
    wr(`EDPO_A_NCNT, ncnt);
    wr(`EDPO_A_CTRL, {29'h0, ctrl});
    wr(`EDPO_A_CTRL, {23'h0, 1'b1, 5'h0, ctrl});
    repeat (4) @(posedge mclk);
  endtask : cfg

  function automatic int exp_edges(input int steps, input logic up);
    int inc;
    inc = cur_lin ? cur_lres : 4 * cur_ppr;
    return ((up ^ cur_rev) ? 1 : -1) * steps * inc / cur_ncnt;
  endfunction : exp_edges

  // Random-paced travel with one origin mark, then compare host counts
  task automatic seg(input string name, input int n, input logic up, input int exp_c,
                     input logic chkw);
    int e0;
    int c0;
    int mark;
    e0   = edges;
    c0   = c_pulses;
    mark = $urandom % 40;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      enc_step   <= 1'b1;
      enc_up     <= up;
      enc_origin <= (i == mark);
      @(posedge mclk);
      enc_step   <= 1'b0;
      enc_origin <= 1'b0;
      repeat (8 + $urandom % 7) @(posedge mclk);
    end
    repeat (300) @(posedge mclk);
    check({name, " edges"}, exp_edges(n, up), edges - e0);
    check({name, " origins"}, exp_c, c_pulses - c0);
    if (chkw) begin
      check({name, " c width"}, 1, c_width >= a_width && c_width <= a_width + 1);
    end
    $display("Test %s done", name);
  endtask : seg

  // ************************************************************
  // Clock, timeout and main sequence
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    {rst, ce, reg_wr, reg_rd, enc_step, enc_up, enc_origin} = 7'b1100000;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    seed      = $urandom(32'h08EC);
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("ctrl", `EDPO_A_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk("ppr", `EDPO_A_PPR, 32'hFFFFFFFF, 32'h800);
    rd_chk("lres", `EDPO_A_LRES, 32'hFFFFFFFF, 32'h14);
    rd_chk("ncnt", `EDPO_A_NCNT, 32'hFFFFFFFF, 32'h100000);
    rd_chk("status", `EDPO_A_STAT, 32'hFFFFFFFF, 32'h0);
    rd_chk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
    $display("Test reset_values done");
    cfg(3'h0, 4, 20, 64);
    seg("rotary_fwd_1", 64, 1'b1, 1, 1'b1);
    seg("rotary_fwd_2", 64, 1'b1, 1, 1'b1);
    rd_chk("armed", `EDPO_A_STAT, 32'h1, 32'h1);
    cfg(3'h1, 4, 20, 64);
    seg("bidir_rev_unarmed", 64, 1'b0, 0, 1'b0);
    rd_chk("not armed", `EDPO_A_STAT, 32'h1, 32'h0);
    seg("bidir_fwd", 64, 1'b1, 1, 1'b0);
    seg("bidir_rev_armed", 64, 1'b0, 1, 1'b0);
    cfg(3'h6, 4, 20, 80);
    seg("linear_motor_rev", 80, 1'b1, 1, 1'b1);
    cfg(3'h0, 16, 20, 64);
    @(posedge mclk);
    enc_step <= 1'b1;
    enc_up   <= 1'b1;
    repeat (200) @(posedge mclk);
    enc_step <= 1'b0;
    rd_chk("overspeed", `EDPO_A_STAT, 32'h2, 32'h2);
    wr(`EDPO_A_STAT, 32'h2);
    rd_chk("overspeed clear", `EDPO_A_STAT, 32'h2, 32'h0);
    $display("Test overspeed done");
    check("host faults", 0, faults);
    stop_test();
  end
endmodule : tb_encoder_divided_pulse_output
